// [gp_consts.svh]
// register offsets, field positions and reset values of the gpio port
`ifndef GP_CONSTS_SVH
`define GP_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define GP_OFS_DATA      8'h00
`define GP_OFS_IRQ_EN    8'h04
`define GP_OFS_DM_LOW    8'h08
`define GP_OFS_DM_HIGH   8'h0C
`define GP_OFS_IO_CFG    8'h10
`define GP_OFS_BYPASS    8'h14

// ************************************************************
// io config fields
// ************************************************************
`define GP_CFG_IRQ_MODE_BIT  0
`define GP_CFG_REG_EN_BIT    1
`define GP_CFG_LEVEL_LSB     4
`define GP_CFG_LEVEL_MSB     5
`define GP_CFG_MASK          8'h33

// ************************************************************
// reset values
// ************************************************************
`define GP_RST_DATA      8'h00
`define GP_RST_IRQ_EN    8'h00
`define GP_RST_DM_LOW    8'h00
`define GP_RST_DM_HIGH   8'hFF
`define GP_RST_IO_CFG    8'h00
`define GP_RST_BYPASS    8'h00

// ************************************************************
// bus response codes
// ************************************************************
`define GP_RESP_OKAY     2'h0
`define GP_RESP_SLVERR   2'h2

`endif

// [gp_pin_model.sv]
// board side of the pins: external drivers, pull-ups and floating lines
`timescale 1ns/1ps

module gp_pin_model
(
    // clock
    input  wire logic       i_clk,
    // device side
    input  wire logic [7:0] i_drv,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pu,
    // board side
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    output logic      [7:0] o_level
);
    logic [7:0] float_q;

    // a floating line toggles so that no stale level can pass for a real one
    initial float_q = 8'h55;
    always @(posedge i_clk) float_q <= ~float_q;

    // device drive wins, a board driver beats a resistive pull-up
    assign o_level = (i_oe & i_drv) | (~i_oe & i_ext_en & i_ext_val)
                   | (~i_oe & ~i_ext_en & (i_pu | float_q));
endmodule

// [gp_pkg.sv]
// types shared by the gpio port design
package gp_pkg;

    // drive mode code, {high bit, low bit}
    typedef enum logic [1:0] {
        GP_DM_PULLUP = 2'h0,
        GP_DM_STRONG = 2'h1,
        GP_DM_HIZ    = 2'h2,
        GP_DM_OPEN   = 2'h3
    } gp_dm_t;

    // regulated strong-high level selection
    typedef logic [1:0] gp_level_t;

endpackage

// [gp_port.sv]
// gpio port: pin drivers, input sampling, pin interrupts and axi4-lite registers
// Notes on behaviour
// - port holds eight identical per-pin blocks
// - written data bit drives pin per mode
// - data read returns sensed pin level
// - all modes but analog keep input
// - 00b pull-up input, 11b open-drain input
// - regulator enable sets strong-high regulated level
// - pull-up mode always pulls to supply
// - config bits 4 and 5 pick level
// - bypass pins output internal function data
// - per-pin open-drain irq, wire-ORed shared
// - pin irq uses only enable and mode
// - mode 0 asserts while pin low
// - mode 1 asserts while pin differs last-read
// - last-read latch selects high or low
// - enable clear keeps pin irq released
// - enabling asserts at once if condition met
// - irq held until one of four events
// - new system irq only on falling line
// - overlapping pins give no second event
// - analog mode reads zero, no useful irq
// - drive mode high bits reset to ones
`timescale 1ns/1ps
`include "gp_consts.svh"

module gp_port
#(
    parameter int NPINS    = 8,
    parameter bit REG_PORT = 1'b1
)
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    // axi4-lite write address
    input  wire logic                  i_awvalid,
    output logic                       o_awready,
    input  wire logic [7:0]            i_awaddr,
    // axi4-lite write data
    input  wire logic                  i_wvalid,
    output logic                       o_wready,
    input  wire logic [31:0]           i_wdata,
    input  wire logic [3:0]            i_wstrb,
    // axi4-lite write response
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    output logic [1:0]                 o_bresp,
    // axi4-lite read address
    input  wire logic                  i_arvalid,
    output logic                       o_arready,
    input  wire logic [7:0]            i_araddr,
    // axi4-lite read data
    output logic                       o_rvalid,
    input  wire logic                  i_rready,
    output logic [31:0]                o_rdata,
    output logic [1:0]                 o_rresp,
    // pins
    input  wire logic [NPINS-1:0]      i_pin,
    output logic      [NPINS-1:0]      o_pin,
    output logic      [NPINS-1:0]      o_pin_oe,
    output logic      [NPINS-1:0]      o_pin_pullup,
    output logic      [NPINS-1:0]      o_pin_input_en,
    output logic      [NPINS-1:0]      o_pin_reg_high,
    output gp_pkg::gp_level_t          o_reg_level,
    // bypass from internal functions
    input  wire logic [NPINS-1:0]      i_alt_data,
    input  wire logic [NPINS-1:0]      i_alt_sel,
    // pin interrupts
    output logic      [NPINS-1:0]      o_pin_irq_oe,
    output logic                       o_gpio_irq_n,
    output logic                       o_gpio_irq_event
);
    import gp_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [NPINS-1:0] data_q;
    logic [NPINS-1:0] irq_en_q;
    logic [NPINS-1:0] dm_low_q;
    logic [NPINS-1:0] dm_high_q;
    logic [NPINS-1:0] bypass_q;
    logic [7:0]       cfg_q;
    logic [NPINS-1:0] last_read_q;
    logic [NPINS-1:0] sync1_q;
    logic [NPINS-1:0] sync2_q;
    logic             irq_any_q;
    logic             event_q;

    // ************************************************************
    // bus handshake state
    // ************************************************************
    logic             aw_got_q;
    logic             w_got_q;
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             bvalid_q;
    logic [1:0]       bresp_q;
    logic             rvalid_q;
    logic [31:0]      rdata_q;
    logic [1:0]       rresp_q;

    logic             aw_hs;
    logic             w_hs;
    logic             ar_hs;
    logic             do_write;
    logic [7:0]       wr_addr;
    logic [31:0]      wr_data;
    logic [3:0]       wr_strb;
    logic             wr_lane0;
    logic             wr_hit;
    logic [NPINS-1:0] sensed;
    logic [NPINS-1:0] pin_irq;
    logic [31:0]      rd_mux;
    logic             rd_hit;
    logic             irq_mode;
    logic             reg_en;
    logic [7:0]       wr_byte;

    // ************************************************************
    // write channel
    // ************************************************************
    // address and data are taken in either order; the response waits for both
    assign o_awready = ~aw_got_q & ~bvalid_q;
    assign o_wready  = ~w_got_q & ~bvalid_q;
    assign aw_hs     = i_awvalid & o_awready;
    assign w_hs      = i_wvalid & o_wready;
    assign wr_addr   = aw_got_q ? awaddr_q : i_awaddr;
    assign wr_data   = w_got_q ? wdata_q : i_wdata;
    assign wr_strb   = w_got_q ? wstrb_q : i_wstrb;
    assign do_write  = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~bvalid_q;
    assign wr_lane0  = do_write & wr_strb[0];
    assign wr_byte   = wr_data[7:0];

    always_comb
    begin
        case (wr_addr)
            `GP_OFS_DATA,
            `GP_OFS_IRQ_EN,
            `GP_OFS_DM_LOW,
            `GP_OFS_DM_HIGH,
            `GP_OFS_IO_CFG,
            `GP_OFS_BYPASS: wr_hit = 1'b1;
            default:        wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end
        else
        begin
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end
            else
            begin
                if (aw_hs)
                begin
                    aw_got_q <= 1'b1;
                    awaddr_q <= i_awaddr;
                end
                if (w_hs)
                begin
                    w_got_q <= 1'b1;
                    wdata_q <= i_wdata;
                    wstrb_q <= i_wstrb;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `GP_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
        end
        else if (bvalid_q & i_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;

    // ************************************************************
    // configuration registers
    // ************************************************************
    // registers are eight bits wide; only byte lane 0 is stored
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            data_q    <= NPINS'(`GP_RST_DATA);
            irq_en_q  <= NPINS'(`GP_RST_IRQ_EN);
            dm_low_q  <= NPINS'(`GP_RST_DM_LOW);
            dm_high_q <= NPINS'(`GP_RST_DM_HIGH);
            cfg_q     <= `GP_RST_IO_CFG;
            bypass_q  <= NPINS'(`GP_RST_BYPASS);
        end
        else if (wr_lane0)
        begin
            case (wr_addr)
                `GP_OFS_DATA:    data_q    <= wr_byte[NPINS-1:0];
                `GP_OFS_IRQ_EN:  irq_en_q  <= wr_byte[NPINS-1:0];
                `GP_OFS_DM_LOW:  dm_low_q  <= wr_byte[NPINS-1:0];
                `GP_OFS_DM_HIGH: dm_high_q <= wr_byte[NPINS-1:0];
                `GP_OFS_IO_CFG:  cfg_q     <= wr_byte & `GP_CFG_MASK;
                `GP_OFS_BYPASS:  bypass_q  <= wr_byte[NPINS-1:0];
                default:         cfg_q     <= cfg_q;
            endcase
        end
    end

    assign irq_mode    = cfg_q[`GP_CFG_IRQ_MODE_BIT];
    assign reg_en      = cfg_q[`GP_CFG_REG_EN_BIT] & REG_PORT;
    assign o_reg_level = cfg_q[`GP_CFG_LEVEL_MSB:`GP_CFG_LEVEL_LSB];

    // ************************************************************
    // input synchroniser
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
        end
    end

    // ************************************************************
    // per-pin blocks
    // ************************************************************
    // every pin is the same slice; only the regulated port uses reg_en
    genvar g;
    generate
        for (g = 0; g < NPINS; g++)
        begin : g_pin
            gp_dm_t dm;
            logic   dout;
            logic   cond;

            assign dm   = gp_dm_t'({dm_high_q[g], dm_low_q[g]});
            assign dout = (bypass_q[g] | i_alt_sel[g]) ? i_alt_data[g] : data_q[g];

            always_comb
            begin
                o_pin[g]          = 1'b0;
                o_pin_oe[g]       = 1'b0;
                o_pin_pullup[g]   = 1'b0;
                o_pin_reg_high[g] = 1'b0;
                o_pin_input_en[g] = 1'b1;
                case (dm)
                    GP_DM_PULLUP:
                    begin
                        // pull-up goes to supply whatever the regulator says
                        o_pin_oe[g]     = ~dout;
                        o_pin_pullup[g] = dout;
                    end
                    GP_DM_STRONG:
                    begin
                        o_pin[g]          = dout;
                        o_pin_oe[g]       = 1'b1;
                        o_pin_reg_high[g] = dout & reg_en;
                    end
                    GP_DM_HIZ:
                    begin
                        o_pin_input_en[g] = 1'b0;
                    end
                    GP_DM_OPEN:
                    begin
                        o_pin_oe[g] = ~dout;
                    end
                    default:
                    begin
                        o_pin_input_en[g] = 1'b0;
                    end
                endcase
            end

            // analog mode blocks the input so it reads zero
            assign sensed[g] = sync2_q[g] & o_pin_input_en[g];

            // low mode, or change against the last value read
            assign cond       = irq_mode ? (sensed[g] ^ last_read_q[g]) : ~sensed[g];
            // purely combinational, so an enable or a mode change acts at once
            assign pin_irq[g] = irq_en_q[g] & cond;
        end
    endgenerate

    // open-drain pull of each pin onto the shared line
    assign o_pin_irq_oe = pin_irq;

    // ************************************************************
    // read channel
    // ************************************************************
    assign o_arready = ~rvalid_q;
    assign ar_hs     = i_arvalid & o_arready;

    always_comb
    begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (i_araddr)
            `GP_OFS_DATA:    rd_mux[NPINS-1:0] = sensed;
            `GP_OFS_IRQ_EN:  rd_mux[NPINS-1:0] = irq_en_q;
            `GP_OFS_DM_LOW:  rd_mux[NPINS-1:0] = dm_low_q;
            `GP_OFS_DM_HIGH: rd_mux[NPINS-1:0] = dm_high_q;
            `GP_OFS_IO_CFG:  rd_mux[7:0]       = cfg_q;
            `GP_OFS_BYPASS:  rd_mux[NPINS-1:0] = bypass_q;
            default:         rd_hit            = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `GP_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
        end
        else if (rvalid_q & i_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;

    // ************************************************************
    // last-read latch
    // ************************************************************
    // a data read refreshes it, which is how a handler releases change mode
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            last_read_q <= '0;
        end
        else if (ar_hs && (i_araddr == `GP_OFS_DATA))
        begin
            last_read_q <= sensed;
        end
    end

    // ************************************************************
    // shared interrupt line
    // ************************************************************
    // wired-OR: low while any pin pulls; one event per falling edge only
    assign o_gpio_irq_n = ~(|pin_irq);

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_any_q <= 1'b0;
            event_q   <= 1'b0;
        end
        else
        begin
            irq_any_q <= |pin_irq;
            event_q   <= (|pin_irq) & ~irq_any_q;
        end
    end

    assign o_gpio_irq_event = event_q;

endmodule

// [gp_port_props.sv]
// assertion checker for the gpio port, bound to its top module
`timescale 1ns/1ps
`include "gp_consts.svh"

module gp_port_props
#(
    parameter int NPINS = 8
)
(
    // clock, reset and bus
    input wire logic             i_clk,
    input wire logic             i_nrst,
    input wire logic             i_arvalid,
    input wire logic             o_arready,
    input wire logic [7:0]       i_araddr,
    input wire logic             o_bvalid,
    input wire logic             o_rvalid,
    input wire logic [31:0]      o_rdata,
    // pins and interrupts
    input wire logic [NPINS-1:0] i_pin,
    input wire logic [NPINS-1:0] o_pin,
    input wire logic [NPINS-1:0] o_pin_oe,
    input wire logic [NPINS-1:0] o_pin_pullup,
    input wire logic [NPINS-1:0] o_pin_input_en,
    input wire logic [NPINS-1:0] o_pin_reg_high,
    input wire logic [NPINS-1:0] o_pin_irq_oe,
    input wire logic             o_gpio_irq_n,
    input wire logic             o_gpio_irq_event
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // ********************************
    // sequences and properties
    // ********************************
    sequence s_data_read;
        i_arvalid && o_arready && i_araddr == `GP_OFS_DATA;
    endsequence
    sequence s_line_fall;
        $fell(o_gpio_irq_n);
    endsequence
    property p_wire_or;
        o_gpio_irq_n == !(|o_pin_irq_oe);
    endproperty
    property p_event;
        s_line_fall |=> o_gpio_irq_event;
    endproperty
    property p_single_event;
        o_gpio_irq_event |-> !$past(o_gpio_irq_n) && $past(o_gpio_irq_n, 2);
    endproperty
    property p_hiz_quiet;
        (~o_pin_input_en & (o_pin_oe | o_pin_pullup | o_pin_reg_high)) == {NPINS{1'b0}};
    endproperty
    property p_reg_high;
        (o_pin_reg_high & ~(o_pin_oe & o_pin)) == {NPINS{1'b0}};
    endproperty
    property p_pullup;
        (o_pin_pullup & (o_pin_oe | o_pin_reg_high)) == {NPINS{1'b0}};
    endproperty
    // pin changes reach the irq two edges late, register effects right after the write
    property p_irq_cause;
        $changed(o_pin_irq_oe) |-> $rose(o_bvalid) || $rose(o_rvalid)
            || $past(i_pin, 2) != $past(i_pin, 3);
    endproperty
    property p_data_read;
        s_data_read |=> o_rdata[NPINS-1:0] == ($past(i_pin, 3) & $past(o_pin_input_en));
    endproperty

    a_wire_or: assert property (p_wire_or)
        else $error("shared irq line disagrees with pin pulls");
    a_event: assert property (p_event)
        else $error("no irq event after shared line fell");
    a_single_event: assert property (p_single_event)
        else $error("irq event without a fall of the shared line");
    a_hiz_quiet: assert property (p_hiz_quiet)
        else $error("pin driven while its input is off");
    a_reg_high: assert property (p_reg_high)
        else $error("regulated high without strong high drive");
    a_pullup: assert property (p_pullup)
        else $error("pull-up together with drive");
    a_irq_cause: assert property (p_irq_cause)
        else $error("pin irq changed without cause");
    a_data_read: assert property (p_data_read)
        else $error("data read not the synchronised pin level");
endmodule

bind gp_port gp_port_props #(.NPINS(NPINS)) i_gp_port_props (.*);

// [gp_port_tb.sv]
// testbench for the gpio port: registers, drive modes and pin interrupts
`timescale 1ns/1ps
`include "gp_consts.svh"

module gp_port_tb;
    import gp_pkg::*;
    logic i_clk = 1'b0, i_nrst = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_alt_data = 8'h00, i_alt_sel = 8'h00;
    logic [7:0] ext_en = 8'hFF, ext_val = 8'hFF, i_pin;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h1;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_gpio_irq_n, o_gpio_irq_event;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    logic [7:0] o_pin, o_pin_oe, o_pin_pullup, o_pin_input_en, o_pin_reg_high, o_pin_irq_oe;
    gp_level_t o_reg_level;
    int n_errors = 0, samples_checked = 0, n_events = 0;

    gp_port #(.NPINS(8), .REG_PORT(1'b1)) i_gp_port (.*);
    gp_pin_model i_gp_pin_model (.i_clk(i_clk), .i_drv(o_pin), .i_oe(o_pin_oe),
        .i_pu(o_pin_pullup), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pin));

    initial forever #2.5 i_clk = ~i_clk;
    // counted mid-cycle, so a check on the edge after the pulse already sees it
    always @(negedge i_clk) if (o_gpio_irq_event === 1'b1) n_events <= n_events + 1;

    // ********************************
    // shared tasks
    // ********************************
    task finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // handshakes are judged before the edge, released right after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rsp;
        bit done;
        done = 0;
        @(posedge i_clk);
        i_awvalid <= 1'b1; i_awaddr <= a; i_wvalid <= 1'b1; i_wdata <= {24'h000000, d};
        i_bready <= 1'b1;
        for (int k = 0; k < 20 && !done; k++)
        begin
            @(negedge i_clk);
            ta = i_awvalid && o_awready; tw = i_wvalid && o_wready; tb = o_bvalid;
            rsp = o_bresp;
            @(posedge i_clk);
            if (ta) i_awvalid <= 1'b0;
            if (tw) i_wvalid <= 1'b0;
            if (tb)
            begin
                i_bready <= 1'b0; done = 1;
            end
        end
        if (!done)
        begin
            n_errors++; $display("Error write %h expected response seen none", a); finish_test;
        end
        chk("bresp", {6'h00, er}, {6'h00, rsp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic ta, tr;
        logic [1:0] rsp;
        logic [7:0] v;
        bit done;
        done = 0;
        @(posedge i_clk);
        i_arvalid <= 1'b1; i_araddr <= a; i_rready <= 1'b1;
        for (int k = 0; k < 20 && !done; k++)
        begin
            @(negedge i_clk);
            ta = i_arvalid && o_arready; tr = o_rvalid; v = o_rdata[7:0]; rsp = o_rresp;
            @(posedge i_clk);
            if (ta) i_arvalid <= 1'b0;
            if (tr)
            begin
                i_rready <= 1'b0; done = 1;
            end
        end
        if (!done)
        begin
            n_errors++; $display("Error read %h expected data seen none", a); finish_test;
        end
        chk("rresp", {6'h00, er}, {6'h00, rsp});
        chk($sformatf("reg %h", a), exp, v);
    endtask
    task ext(input logic [7:0] en, input logic [7:0] val);
        @(posedge i_clk);
        ext_en <= en; ext_val <= val;
        repeat (4) @(posedge i_clk);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task t_reset;
        rd(`GP_OFS_DATA, 8'h00, `GP_RESP_OKAY);
        rd(`GP_OFS_IRQ_EN, `GP_RST_IRQ_EN, `GP_RESP_OKAY);
        rd(`GP_OFS_DM_LOW, `GP_RST_DM_LOW, `GP_RESP_OKAY);
        rd(`GP_OFS_DM_HIGH, `GP_RST_DM_HIGH, `GP_RESP_OKAY);
        rd(`GP_OFS_IO_CFG, `GP_RST_IO_CFG, `GP_RESP_OKAY);
        rd(`GP_OFS_BYPASS, `GP_RST_BYPASS, `GP_RESP_OKAY);
        rd(8'h18, 8'h00, `GP_RESP_SLVERR);
        wr(8'h18, 8'hFF, `GP_RESP_SLVERR);
        // a write without byte lane 0 is answered but stores nothing
        i_wstrb <= 4'h0;
        wr(`GP_OFS_IRQ_EN, 8'hFF, `GP_RESP_OKAY);
        rd(`GP_OFS_IRQ_EN, `GP_RST_IRQ_EN, `GP_RESP_OKAY);
        i_wstrb <= 4'h1;
        chk("input_en", 8'h00, o_pin_input_en);
        $display("t_reset done");
    endtask
    task t_drive;
        wr(`GP_OFS_DM_HIGH, 8'h00, `GP_RESP_OKAY);
        wr(`GP_OFS_DM_LOW, 8'hFF, `GP_RESP_OKAY);
        wr(`GP_OFS_DATA, 8'hA5, `GP_RESP_OKAY);
        chk("pin", 8'hA5, o_pin);
        chk("oe", 8'hFF, o_pin_oe);
        wr(`GP_OFS_IO_CFG, 8'h32, `GP_RESP_OKAY);
        chk("level", 8'h03, {6'h00, o_reg_level});
        chk("reg_high", 8'hA5, o_pin_reg_high);
        wr(`GP_OFS_IO_CFG, 8'h10, `GP_RESP_OKAY);
        chk("reg_high off", 8'h00, o_pin_reg_high);
        wr(`GP_OFS_IO_CFG, 8'h02, `GP_RESP_OKAY);
        wr(`GP_OFS_DM_LOW, 8'h00, `GP_RESP_OKAY);
        chk("pullup", 8'hA5, o_pin_pullup);
        chk("pullup reg", 8'h00, o_pin_reg_high);
        ext(8'h00, 8'h00);
        rd(`GP_OFS_DATA, 8'hA5, `GP_RESP_OKAY);
        ext(8'h01, 8'h00);
        rd(`GP_OFS_DATA, 8'hA4, `GP_RESP_OKAY);
        wr(`GP_OFS_IO_CFG, 8'h00, `GP_RESP_OKAY);
        $display("t_drive done");
    endtask
    task t_modes;
        ext(8'hFF, 8'h0F);
        wr(`GP_OFS_DM_HIGH, 8'hFF, `GP_RESP_OKAY);
        wr(`GP_OFS_DM_LOW, 8'hFF, `GP_RESP_OKAY);
        wr(`GP_OFS_DATA, 8'h0F, `GP_RESP_OKAY);
        chk("open oe", 8'hF0, o_pin_oe);
        chk("open input", 8'hFF, o_pin_input_en);
        rd(`GP_OFS_DATA, 8'h0F, `GP_RESP_OKAY);
        wr(`GP_OFS_DM_LOW, 8'h00, `GP_RESP_OKAY);
        chk("analog input", 8'h00, o_pin_input_en);
        rd(`GP_OFS_DATA, 8'h00, `GP_RESP_OKAY);
        $display("t_modes done");
    endtask
    task t_bypass;
        wr(`GP_OFS_DM_HIGH, 8'h00, `GP_RESP_OKAY);
        wr(`GP_OFS_DM_LOW, 8'hFF, `GP_RESP_OKAY);
        wr(`GP_OFS_DATA, 8'h00, `GP_RESP_OKAY);
        @(posedge i_clk);
        i_alt_data <= 8'h03; i_alt_sel <= 8'h01;
        @(posedge i_clk);
        chk("alt sel pin", 8'h01, o_pin);
        wr(`GP_OFS_BYPASS, 8'h02, `GP_RESP_OKAY);
        chk("alt reg pin", 8'h03, o_pin);
        wr(`GP_OFS_BYPASS, 8'h00, `GP_RESP_OKAY);
        i_alt_sel <= 8'h00;
        $display("t_bypass done");
    endtask
    task t_irq_low;
        int e0;
        ext(8'hFF, 8'hFF);
        wr(`GP_OFS_DM_HIGH, 8'hFF, `GP_RESP_OKAY);
        wr(`GP_OFS_DATA, 8'hFF, `GP_RESP_OKAY);
        e0 = n_events;
        wr(`GP_OFS_IRQ_EN, 8'h01, `GP_RESP_OKAY);
        chk("irq high pin", 8'h00, o_pin_irq_oe);
        ext(8'hFF, 8'hFE);
        chk("irq low pin", 8'h01, o_pin_irq_oe);
        chk("line", 8'h00, {7'h00, o_gpio_irq_n});
        chk("events", 8'h01, 8'(n_events - e0));
        ext(8'hFF, 8'hFC);
        wr(`GP_OFS_IRQ_EN, 8'h03, `GP_RESP_OKAY);
        chk("irq at enable", 8'h03, o_pin_irq_oe);
        ext(8'hFF, 8'hFD);
        chk("irq first off", 8'h02, o_pin_irq_oe);
        chk("no new event", 8'h01, 8'(n_events - e0));
        wr(`GP_OFS_IRQ_EN, 8'h00, `GP_RESP_OKAY);
        chk("irq disabled", 8'h00, o_pin_irq_oe);
        chk("line off", 8'h01, {7'h00, o_gpio_irq_n});
        $display("t_irq_low done");
    endtask
    task t_irq_chg;
        wr(`GP_OFS_IO_CFG, 8'h01, `GP_RESP_OKAY);
        rd(`GP_OFS_DATA, 8'hFD, `GP_RESP_OKAY);
        wr(`GP_OFS_IRQ_EN, 8'h01, `GP_RESP_OKAY);
        chk("chg same", 8'h00, o_pin_irq_oe);
        ext(8'hFF, 8'hFC);
        chk("chg to low", 8'h01, o_pin_irq_oe);
        rd(`GP_OFS_DATA, 8'hFC, `GP_RESP_OKAY);
        chk("chg after read", 8'h00, o_pin_irq_oe);
        ext(8'hFF, 8'hFD);
        chk("chg to high", 8'h01, o_pin_irq_oe);
        wr(`GP_OFS_IO_CFG, 8'h00, `GP_RESP_OKAY);
        chk("mode change", 8'h00, o_pin_irq_oe);
        $display("t_irq_chg done");
    endtask

    initial
    begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_reset;
        t_drive;
        t_modes;
        t_bypass;
        t_irq_low;
        t_irq_chg;
        finish_test;
    end
endmodule
